// ### rtl/wmc_mode_ctrl.v
// working-mode selection and mode-switch sequencing
`timescale 1ns/100ps
`default_nettype none
`include "wmc_map.vh"

// Summary of operation
// - two pins decode into four modes
// - idle pin change takes effect within 1ms
// - pending serial data sent before switching
// - radio data emitted on serial before switching
// - switch applied while busy indicator low
// - pin changes while host streams data wait for the drain
// - sleep entered within 1ms after draining
// - latest pin state applied within 1ms after work
// - transparent mode transmits serial input bytes
// - transparent mode receiver on, forwards payloads
// - wake mode acts as sender or receiver
// - wake sender sends wake code before payload
// - wake mode reception same as transparent
// - configuration mode radio off, registers reachable
// - deep sleep has no radio activity
// - transparent mode accepts over-air configuration command
// - busy low from traffic does not block mode-pin detection
// - leaving sleep reloads parameters, busy held low
module wmc_mode_ctrl #(
  parameter [17:0] SWITCH_CYC = `WMC_SWITCH_CYC,
  parameter [17:0] RELOAD_CYC = `WMC_RELOAD_CYC_DEF,
  parameter [17:0] WAKE_CYC   = `WMC_WAKE_CYC_DEF
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_b,
  // mode pins from host
  input  wire       modeSelectHigh,
  input  wire       modeSelectLow,
  // traffic status from datapath
  input  wire       serialRxPending,
  input  wire       serialRxActive,
  input  wire       radioTxBusy,
  input  wire       serialTxPending,
  input  wire       worSenderCfg,
  input  wire       airCfgDetect,
  // busy indicator, high when ready
  output reg        busyReady_ff,
  // current mode and path enables
  output reg  [1:0] activeMode_ff,
  output reg        radioTxEn_ff,
  output reg        radioRxEn_ff,
  output reg        serialToRadioEn_ff,
  output reg        radioToSerialEn_ff,
  output reg        wakeCodeEn_ff,
  output reg        cfgPortEn_ff,
  output reg        airCfgEn_ff,
  output reg        sleepEn_ff,
  output reg        reloadReq_ff
);

  localparam [1:0] ST_RELOAD = 2'h0;
  localparam [1:0] ST_RUN    = 2'h1;
  localparam [1:0] ST_DRAIN  = 2'h2;
  localparam [1:0] ST_SWITCH = 2'h3;

  reg        rstSync1_ff;
  reg        rstSync2_ff;
  wire       rstLocal_b;
  reg  [2:0] pinHi_ff;
  reg  [2:0] pinLo_ff;
  reg  [1:0] pinMode_ff;
  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [1:0] targetMode_ff;
  reg  [1:0] nxt_targetMode;
  reg  [1:0] nxt_activeMode;
  reg  [17:0] count_ff;
  reg  [17:0] nxt_count;
  reg  [17:0] wakeCnt_ff;
  reg        wakeSent_ff;
  reg        workBusy;
  reg        txWorkBusy;

  // helpers shared by the counters and the path enables
  function counterDone;
    input [17:0] cnt;
    input [17:0] limit;
    begin
      counterDone = (cnt >= limit);
    end
  endfunction

  function [17:0] countUp;
    input [17:0] cnt;
    begin
      countUp = cnt + 18'h1;
    end
  endfunction

  function [17:0] countDown;
    input [17:0] cnt;
    begin
      countDown = cnt - 18'h1;
    end
  endfunction

  function leavesSleep;
    input [1:0] fromMode;
    input [1:0] toMode;
    begin
      // sleep exit must pass through a parameter reload
      leavesSleep = (fromMode == `WMC_MODE_SLEEP) &&
                    (toMode != `WMC_MODE_SLEEP);
    end
  endfunction

  function txPathOn;
    input [1:0] mode;
    input       worSender;
    begin
      case (mode)
        `WMC_MODE_TRANSP: txPathOn = 1'b1;
        `WMC_MODE_WOR:    txPathOn = worSender;
        default:          txPathOn = 1'b0;
      endcase
    end
  endfunction

  function rxPathOn;
    input [1:0] mode;
    begin
      case (mode)
        `WMC_MODE_TRANSP: rxPathOn = 1'b1;
        `WMC_MODE_WOR:    rxPathOn = 1'b1;
        default:          rxPathOn = 1'b0;
      endcase
    end
  endfunction

  // reset release through two flops
  // asserts at once, lets go only on the clock
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  assign rstLocal_b = rstSync2_ff;

  // pins are async to clk_sys; third stage filters glitches
  // both late stages must agree before a bit is taken
  always @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      pinHi_ff   <= 3'h0;
      pinLo_ff   <= 3'h0;
      pinMode_ff <= `WMC_MODE_TRANSP;
    end else begin
      pinHi_ff <= {pinHi_ff[1:0], modeSelectHigh};
      pinLo_ff <= {pinLo_ff[1:0], modeSelectLow};
      if (pinHi_ff[1] == pinHi_ff[2]) begin
        pinMode_ff[1] <= pinHi_ff[2];
      end
      if (pinLo_ff[1] == pinLo_ff[2]) begin
        pinMode_ff[0] <= pinLo_ff[2];
      end
    end
  end

  // any outstanding traffic keeps the module busy
  always @* begin
    txWorkBusy = serialRxPending | radioTxBusy | serialRxActive;
    workBusy   = txWorkBusy | serialTxPending;
  end

  always @* begin
    nxt_state      = state_ff;
    nxt_targetMode = targetMode_ff;
    nxt_activeMode = activeMode_ff;
    nxt_count      = count_ff;
    case (state_ff)
      ST_RELOAD: begin
        // parameters reloaded with busy low
        if (counterDone(count_ff, RELOAD_CYC)) begin
          nxt_state = ST_RUN;
          nxt_count = 18'h0;
        end else begin
          nxt_count = countUp(count_ff);
        end
      end
      ST_RUN: begin
        // detection runs even with traffic; streaming defers the switch
        if (pinMode_ff != activeMode_ff) begin
          nxt_targetMode = pinMode_ff;
          nxt_count      = 18'h0;
          if (workBusy) begin
            nxt_state = ST_DRAIN;
          end else begin
            nxt_state = ST_SWITCH;
          end
        end
      end
      ST_DRAIN: begin
        // wait for traffic, then pick up latest pins
        if (!workBusy) begin
          nxt_targetMode = pinMode_ff;
          nxt_state      = ST_SWITCH;
          nxt_count      = 18'h0;
        end
      end
      ST_SWITCH: begin
        // fixed switch delay of SWITCH_CYC-1 cycles, just under 1ms
        if (counterDone(count_ff, SWITCH_CYC - 18'h2)) begin
          nxt_activeMode = targetMode_ff;
          nxt_count      = 18'h0;
          if (leavesSleep(activeMode_ff, targetMode_ff)) begin
            nxt_state = ST_RELOAD;
          end else begin
            nxt_state = ST_RUN;
          end
        end else begin
          nxt_count = countUp(count_ff);
        end
      end
      default: begin
        nxt_state = ST_RELOAD;
        nxt_count = 18'h0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      state_ff      <= ST_RELOAD;
      targetMode_ff <= `WMC_MODE_TRANSP;
      activeMode_ff <= `WMC_MODE_TRANSP;
      count_ff      <= 18'h0;
    end else begin
      state_ff      <= nxt_state;
      targetMode_ff <= nxt_targetMode;
      activeMode_ff <= nxt_activeMode;
      count_ff      <= nxt_count;
    end
  end

  // wake code runs ahead of each wake-mode payload
  // one code per payload; wakeSent_ff stops an endless rerun
  always @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      wakeCnt_ff    <= 18'h0;
      wakeCodeEn_ff <= 1'b0;
      wakeSent_ff   <= 1'b0;
    end else if (activeMode_ff != `WMC_MODE_WOR || !worSenderCfg) begin
      // leaving the sender role cuts the code short
      wakeCnt_ff    <= 18'h0;
      wakeCodeEn_ff <= 1'b0;
      wakeSent_ff   <= 1'b0;
    end else if (wakeCnt_ff == 18'h0 && !wakeSent_ff &&
                 serialRxPending && !radioTxBusy) begin
      wakeCnt_ff    <= WAKE_CYC;
      wakeCodeEn_ff <= 1'b1;
      wakeSent_ff   <= 1'b1;
    end else if (wakeCnt_ff > 18'h1) begin
      wakeCnt_ff <= countDown(wakeCnt_ff);
    end else if (wakeCnt_ff == 18'h1) begin
      wakeCnt_ff    <= 18'h0;
      wakeCodeEn_ff <= 1'b0;
    end else if (!serialRxPending && !radioTxBusy) begin
      // payload gone; the next one gets its own code
      wakeSent_ff <= 1'b0;
    end
  end

  // busy low for reload, traffic or pending switch
  // follows nxt_state so it falls with the switch decision
  always @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      busyReady_ff <= 1'b0;
    end else begin
      busyReady_ff <= (nxt_state == ST_RUN) && !workBusy;
    end
  end

  // path enables follow the adopted mode
  always @(posedge clk_sys or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      radioTxEn_ff       <= 1'b0;
      radioRxEn_ff       <= 1'b0;
      serialToRadioEn_ff <= 1'b0;
      radioToSerialEn_ff <= 1'b0;
      cfgPortEn_ff       <= 1'b0;
      airCfgEn_ff        <= 1'b0;
      sleepEn_ff         <= 1'b0;
      reloadReq_ff       <= 1'b0;
    end else begin
      reloadReq_ff <= (nxt_state == ST_RELOAD);
      // keyed on nxt_activeMode so enables move with activeMode_ff
      case (nxt_activeMode)
        `WMC_MODE_TRANSP: begin
          radioTxEn_ff       <= txPathOn(nxt_activeMode, worSenderCfg);
          radioRxEn_ff       <= rxPathOn(nxt_activeMode);
          serialToRadioEn_ff <= txPathOn(nxt_activeMode, worSenderCfg);
          radioToSerialEn_ff <= rxPathOn(nxt_activeMode);
          cfgPortEn_ff       <= 1'b0;
          airCfgEn_ff        <= airCfgDetect;
          sleepEn_ff         <= 1'b0;
        end
        `WMC_MODE_WOR: begin
          radioTxEn_ff       <= txPathOn(nxt_activeMode, worSenderCfg);
          radioRxEn_ff       <= rxPathOn(nxt_activeMode);
          serialToRadioEn_ff <= txPathOn(nxt_activeMode, worSenderCfg);
          radioToSerialEn_ff <= rxPathOn(nxt_activeMode);
          cfgPortEn_ff       <= 1'b0;
          airCfgEn_ff        <= 1'b0;
          sleepEn_ff         <= 1'b0;
        end
        `WMC_MODE_CONFIG: begin
          radioTxEn_ff       <= 1'b0;
          radioRxEn_ff       <= 1'b0;
          serialToRadioEn_ff <= 1'b0;
          radioToSerialEn_ff <= 1'b0;
          cfgPortEn_ff       <= 1'b1;
          airCfgEn_ff        <= 1'b0;
          sleepEn_ff         <= 1'b0;
        end
        default: begin
          radioTxEn_ff       <= 1'b0;
          radioRxEn_ff       <= 1'b0;
          serialToRadioEn_ff <= 1'b0;
          radioToSerialEn_ff <= 1'b0;
          cfgPortEn_ff       <= 1'b0;
          airCfgEn_ff        <= 1'b0;
          sleepEn_ff         <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/wmc_map.vh
// constants for the working-mode controller
`ifndef WMC_MAP_VH
`define WMC_MAP_VH
`define WMC_MODE_TRANSP    2'h0
`define WMC_MODE_WOR       2'h1
`define WMC_MODE_CONFIG    2'h2
`define WMC_MODE_SLEEP     2'h3
`define WMC_CLK_MHZ        125
`define WMC_SWITCH_US      1000
// 1000 us at 125 MHz, sized to the 18-bit counters
`define WMC_SWITCH_CYC     18'h1e848
`define WMC_RELOAD_CYC_DEF 18'h10
`define WMC_WAKE_CYC_DEF   18'h20
`endif

// ### sim/wmc_mode_ctrl_sva.sv
// assertions for the working-mode controller
`timescale 1ns/100ps
`default_nettype none
module wmc_mode_ctrl_sva #(
  parameter [17:0] SWITCH_CYC = 18'h14,
  parameter [17:0] RELOAD_CYC = 18'h4
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // inputs
  input wire logic       modeSelectHigh,
  input wire logic       modeSelectLow,
  input wire logic       serialRxPending,
  input wire logic       serialRxActive,
  input wire logic       radioTxBusy,
  input wire logic       serialTxPending,
  input wire logic       airCfgDetect,
  // outputs
  input wire logic       busyReady_ff,
  input wire logic [1:0] activeMode_ff,
  input wire logic       radioTxEn_ff,
  input wire logic       radioRxEn_ff,
  input wire logic       cfgPortEn_ff,
  input wire logic       airCfgEn_ff,
  input wire logic       sleepEn_ff
);
  wire logic        tr = serialRxPending | serialRxActive | radioTxBusy | serialTxPending;
  logic      [17:0] lowCnt_ff;
  // counts idle busy-low time; traffic restarts it
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) lowCnt_ff <= 18'h0;
    else lowCnt_ff <= (busyReady_ff || tr) ? 18'h0 : lowCnt_ff + 18'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence pinReq;
    busyReady_ff && !tr && {modeSelectHigh, modeSelectLow} != activeMode_ff;
  endsequence
  sequence sleepExit;
    $past(activeMode_ff) == 2'h3 && activeMode_ff != 2'h3;
  endsequence
  a_cfg_radio_off: assert property (activeMode_ff == 2'h2 && busyReady_ff |->
    cfgPortEn_ff && !radioTxEn_ff && !radioRxEn_ff) else $error("config mode radio on");
  a_sleep_quiet: assert property (sleepEn_ff |-> !radioTxEn_ff && !radioRxEn_ff)
    else $error("radio active in sleep");
  a_transp_rx_on: assert property (activeMode_ff == 2'h0 && busyReady_ff |-> radioRxEn_ff)
    else $error("receiver off in transparent mode");
  a_busy_traffic: assert property (tr |=> !busyReady_ff)
    else $error("ready during traffic");
  a_pin_detect: assert property (pinReq [*2] |-> ##[0:6] !busyReady_ff)
    else $error("pin change not taken");
  a_switch_bound: assert property (lowCnt_ff <= SWITCH_CYC + RELOAD_CYC + 18'h8)
    else $error("switch too slow");
  a_mode_decode: assert property ($changed(activeMode_ff) |->
    activeMode_ff == {modeSelectHigh, modeSelectLow} && $past(busyReady_ff) == 1'b0)
    else $error("bad mode adopted");
  a_sleep_reload: assert property (sleepExit |-> !busyReady_ff [*4] ##[1:4] busyReady_ff)
    else $error("no reload after sleep");
  a_air_cfg: assert property (airCfgEn_ff == ($past(airCfgDetect) && activeMode_ff == 2'h0))
    else $error("air config enable wrong");
endmodule
bind wmc_mode_ctrl wmc_mode_ctrl_sva #(.SWITCH_CYC(SWITCH_CYC), .RELOAD_CYC(RELOAD_CYC)) u_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .modeSelectHigh(modeSelectHigh),
  .modeSelectLow(modeSelectLow), .serialRxPending(serialRxPending),
  .serialRxActive(serialRxActive), .radioTxBusy(radioTxBusy),
  .serialTxPending(serialTxPending), .airCfgDetect(airCfgDetect),
  .busyReady_ff(busyReady_ff), .activeMode_ff(activeMode_ff), .radioTxEn_ff(radioTxEn_ff),
  .radioRxEn_ff(radioRxEn_ff), .cfgPortEn_ff(cfgPortEn_ff), .airCfgEn_ff(airCfgEn_ff),
  .sleepEn_ff(sleepEn_ff));
`default_nettype wire

// ### sim/wmc_host_model.sv
// host model driving the mode pins
`timescale 1ns/100ps
`default_nettype none
module wmc_host_model #(
  parameter int HOLD_CYC = 4
) (
  // clock and busy indicator
  input  wire logic clk_sys,
  input  wire logic busyReady,
  // mode pins, two plain outputs
  output var logic  modeSelectHigh,
  output var logic  modeSelectLow
);
  initial {modeSelectHigh, modeSelectLow} = 2'h0;
  task automatic setMode(input logic [1:0] m, input bit polite);
    int n;
    n = 0;
    if (polite) begin
      // wait for ready, then a fixed settle time of HOLD_CYC cycles
      while (busyReady !== 1'b1 && n < 5000) begin
        @(posedge clk_sys);
        n++;
      end
      repeat (HOLD_CYC) @(posedge clk_sys);
    end
    @(negedge clk_sys);
    {modeSelectHigh, modeSelectLow} = m;
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the working-mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench;
  localparam [17:0] SW = 18'h14;
  logic            clk_sys, rst_b, airCfgDetect, worSenderCfg;
  logic      [3:0] tr;
  wire logic       pinH, pinL, busy, txEn, rxEn, cfgEn, airEn, slp, s2r, r2s, wake, rld;
  wire logic [1:0] mode;
  int              fails = 0, samples_checked = 0;
  wmc_mode_ctrl #(.SWITCH_CYC(SW), .RELOAD_CYC(18'h4), .WAKE_CYC(18'h4)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .modeSelectHigh(pinH), .modeSelectLow(pinL),
    .serialRxPending(tr[0]), .serialRxActive(tr[1]), .radioTxBusy(tr[2]),
    .serialTxPending(tr[3]), .worSenderCfg(worSenderCfg), .airCfgDetect(airCfgDetect),
    .busyReady_ff(busy), .activeMode_ff(mode), .radioTxEn_ff(txEn), .radioRxEn_ff(rxEn),
    .serialToRadioEn_ff(s2r), .radioToSerialEn_ff(r2s), .wakeCodeEn_ff(wake),
    .cfgPortEn_ff(cfgEn), .airCfgEn_ff(airEn), .sleepEn_ff(slp), .reloadReq_ff(rld));
  wmc_host_model #(.HOLD_CYC(4)) host (.clk_sys(clk_sys), .busyReady(busy),
    .modeSelectHigh(pinH), .modeSelectLow(pinL));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task results;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // counts falling edges until busy is seen high
  task automatic waitReady(input int lim);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (busy !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("switch time", 1'b1, n <= lim)
  endtask
  task automatic goMode(input logic [1:0] m, input int lim);
    host.setMode(m, 1'b1);
    repeat (8) @(posedge clk_sys);
    waitReady(lim - 8);
    `CHK("mode", m, mode)
    `CHK("cfg port", m == 2'h2, cfgEn)
    `CHK("sleep", m == 2'h3, slp)
    `CHK("rx path", m < 2'h2, rxEn)
    `CHK("tx path", m == 2'h0 || (m == 2'h1 && worSenderCfg), txEn)
    `CHK("serial to radio", m == 2'h0 || (m == 2'h1 && worSenderCfg), s2r)
    `CHK("radio to serial", m < 2'h2, r2s)
    `CHK("reload done", 1'b0, rld)
  endtask
  task automatic t_modes;
    goMode(2'h1, SW + 8);
    goMode(2'h2, SW + 8);
    goMode(2'h3, SW + 8);
    goMode(2'h0, SW + 16);
  endtask
  // wake sender: code leads the payload for WAKE_CYC (4) cycles
  task automatic t_wake;
    worSenderCfg = 1'b1;
    goMode(2'h1, SW + 8);
    @(negedge clk_sys) tr[0] = 1'b1;
    repeat (4) begin
      @(negedge clk_sys);
      `CHK("wake code", 1'b1, wake)
    end
    @(negedge clk_sys);
    `CHK("wake end", 1'b0, wake)
    tr[0] = 1'b0;
    waitReady(SW + 8);
    goMode(2'h0, SW + 8);
  endtask
  // each traffic kind holds off the switch; odd ones ask for sleep
  task automatic t_drain;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys) tr[i] = 1'b1;
      if (i == 1) host.setMode(2'h1, 1'b0);
      host.setMode(i[0] ? 2'h3 : 2'h2, 1'b0);
      repeat (60) @(posedge clk_sys);
      `CHK("held mode", 2'h0, mode)
      @(negedge clk_sys) tr[i] = 1'b0;
      waitReady(SW + 16);
      `CHK("drained mode", i[0] ? 2'h3 : 2'h2, mode)
      goMode(2'h0, SW + 16);
    end
  endtask
  task automatic t_air;
    @(negedge clk_sys) airCfgDetect = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK("air cfg", 1'b1, airEn)
    goMode(2'h2, SW + 8);
    `CHK("air cfg off", 1'b0, airEn)
    airCfgDetect = 1'b0;
    goMode(2'h0, SW + 8);
  endtask
  initial begin
    rst_b = 1'b0;
    tr = 4'h0;
    airCfgDetect = 1'b0;
    worSenderCfg = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK("reload", 1'b1, rld)
    `CHK("busy in reload", 1'b0, busy)
    t_modes;
    t_wake;
    t_drain;
    t_air;
    results;
  end
  // whole run is under 2000 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    fails++;
    results;
  end
endmodule
`default_nettype wire
